//--- dv/spi_host_model.sv
`timescale 1ns/10ps
module spi_host_model (
   output logic      spi_clk,
   output logic      cs_n,
   output logic      serial_data_in,
   input  wire logic miso,
   input  wire logic miso_oe
);
   initial begin
      spi_clk = 1'b0;
      cs_n = 1'b1;
      serial_data_in = 1'b0;
   end
   // Clock idles low between frames; data line is inverted once released
   task automatic frame(input logic [31:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      cs_n = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         serial_data_in = tx[i];
         #6 spi_clk = 1'b1;
         if (i < 8)
            rx = {rx[6:0], miso_oe ? miso : 1'bx};
         #6 spi_clk = 1'b0;
      end
      #6 cs_n = 1'b1;
      serial_data_in = ~serial_data_in;
      #100;
   endtask
endmodule // spi_host_model

//--- dv/status_reg_chk.sv
`timescale 1ns/10ps
module status_reg_chk #(
   parameter int WRITE_CYCLES = 20
) (
   input wire logic       ref_clk,
   input wire logic       rst,
   input wire logic       cs_n,
   input wire logic       array_busy,
   input wire logic       miso_oe,
   input wire logic [7:0] config_status_byte_three,
   input wire logic       busy_flag,
   input wire logic       write_enable_latch,
   input wire logic       hardware_locked_mode,
   input wire logic       extra_latency_select,
   input wire logic [3:0] dual_dummy_clocks,
   input wire logic [3:0] quad_dummy_clocks,
   input wire logic [1:0] drive_strength,
   input wire logic [6:0] drive_percent,
   input wire logic [1:0] wrap_burst_len,
   input wire logic       status_protect_bit,
   input wire logic       quad_pins_enable,
   input wire logic       otp_sector_lock_a,
   input wire logic       otp_sector_lock_b,
   input wire logic       otp_sector_lock_c
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   int busy_cnt;
   // Program/erase time is outside this block, so only status cycles are counted
   always_ff @(posedge ref_clk) begin
      if (rst || !busy_flag || array_busy)
         busy_cnt <= 0;
      else
         busy_cnt <= busy_cnt + 1;
   end
   a_dummy_dual:
   assert property (dual_dummy_clocks == (extra_latency_select ? 4'h8 : 4'h4)) else $error("dual dummy");
   a_dummy_quad:
   assert property (quad_dummy_clocks == (extra_latency_select ? 4'hA : 4'h6)) else $error("quad dummy");
   a_drive_pct:
   assert property (drive_percent == (drive_strength == 2'h0 ? 7'h43 : drive_strength == 2'h1 ?
      7'h64 : drive_strength == 2'h2 ? 7'h32 : 7'h53)) else $error("drive percent");
   a_byte_fields:
   assert property ({config_status_byte_three[7:3], config_status_byte_three[1]} == {
      extra_latency_select, drive_strength, wrap_burst_len, write_enable_latch}) else $error("fields");
   a_blank_sticky:
   assert property (!$past(rst) && !config_status_byte_three[2] |=> !config_status_byte_three[2])
      else $error("blank");
   a_otp_sticky:
   assert property (##1 ($past({otp_sector_lock_a, otp_sector_lock_b, otp_sector_lock_c}) &
      ~{otp_sector_lock_a, otp_sector_lock_b, otp_sector_lock_c}) == 3'h0) else $error("otp lost");
   a_lock_needs_srp:
   assert property (hardware_locked_mode |-> status_protect_bit && !quad_pins_enable) else $error("lock");
   a_wel_cleared:
   assert property ($fell(busy_flag) |-> ##[0:2] !write_enable_latch) else $error("latch kept");
   a_busy_bounded:
   assert property (busy_cnt <= WRITE_CYCLES + 6) else $error("busy too long");
   a_oe_with_cs:
   assert property (cs_n && $past(cs_n) |-> !miso_oe) else $error("output while deselected");
   cover property ($fell(busy_flag));
   cover property (hardware_locked_mode);
   cover property (miso_oe && busy_flag);
endmodule // status_reg_chk
bind status_reg_access status_reg_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
   .ref_clk, .rst, .cs_n, .array_busy, .miso_oe, .config_status_byte_three, .busy_flag,
   .write_enable_latch, .hardware_locked_mode, .extra_latency_select, .dual_dummy_clocks,
   .quad_dummy_clocks, .drive_strength, .drive_percent, .wrap_burst_len, .status_protect_bit,
   .quad_pins_enable, .otp_sector_lock_a, .otp_sector_lock_b, .otp_sector_lock_c);

//--- dv/tb_top.sv
`timescale 1ns/10ps
module tb_top;
   logic       ref_clk = 1'b0;
   logic       rst = 1'b1;
   logic       wp_n = 1'b1;
   logic       array_busy = 1'b0;
   logic       first_program = 1'b0;
   logic       wrap_set = 1'b0;
   logic [1:0] wrap_len = 2'h0;
   logic       spi_clk, cs_n, serial_data_in, miso, miso_oe, busy_flag, write_enable_latch;
   logic       hardware_locked_mode, extra_latency_select, status_protect_bit, protect_invert;
   logic       boot_sector_lock, protect_from_bottom, quad_pins_enable;
   logic       block_protect_level_2, block_protect_level_1, block_protect_level_0;
   logic       otp_sector_lock_a, otp_sector_lock_b, otp_sector_lock_c;
   logic [7:0] config_status_byte_three;
   logic [3:0] dual_dummy_clocks, quad_dummy_clocks;
   logic [1:0] drive_strength, wrap_burst_len;
   logic [6:0] drive_percent;
   logic [7:0] rx;
   logic [7:0] ops [2] = '{8'hC0, 8'h11};
   logic [7:0] dat [2] = '{8'h20, 8'h40};
   logic [7:0] pct [2] = '{8'h64, 8'h32};
   int         miscompares = 0;
   int         cmp_count = 0;
   always #10 ref_clk = ~ref_clk;
   spi_host_model host (.spi_clk, .cs_n, .serial_data_in, .miso, .miso_oe);
   status_reg_access #(.WRITE_CYCLES(20)) dut (
      .ref_clk, .rst, .spi_clk, .cs_n, .serial_data_in, .wp_n, .array_busy, .first_program,
      .wrap_set, .wrap_len, .miso, .miso_oe, .config_status_byte_three, .busy_flag,
      .write_enable_latch, .hardware_locked_mode, .extra_latency_select, .dual_dummy_clocks,
      .quad_dummy_clocks, .drive_strength, .drive_percent, .wrap_burst_len, .status_protect_bit,
      .protect_invert, .boot_sector_lock, .protect_from_bottom, .block_protect_level_2,
      .block_protect_level_1, .block_protect_level_0, .otp_sector_lock_a, .otp_sector_lock_b,
      .otp_sector_lock_c, .quad_pins_enable);
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic rd(input logic [7:0] op, input logic [7:0] exp);
      logic [7:0] r;
      host.frame({16'h0, op, 8'h00}, 16, r);
      check("read byte three", r, exp);
   endtask
   task automatic wr(input logic [31:0] tx, input int n, input bit peek);
      logic [7:0] r;
      host.frame(32'h06, 8, r);
      host.frame(tx, n, r);
      repeat (8) @(posedge ref_clk);
      if (peek)
         rd(8'h15, 8'h07);
      for (int i = 0; i < 100 && busy_flag !== 1'b0; i++) @(posedge ref_clk);
      check("busy end", {7'h0, busy_flag}, 8'h00);
      repeat (3) @(posedge ref_clk);
   endtask
   task automatic print_verdict;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #200000;
      miscompares++;
      print_verdict();
   end
   initial begin
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      check("reset byte", config_status_byte_three, 8'h04);
      check("dual dummy", {4'h0, dual_dummy_clocks}, 8'h04);
      check("quad dummy", {4'h0, quad_dummy_clocks}, 8'h06);
      check("drive pct", {1'b0, drive_percent}, 8'h43);
      rd(8'h95, 8'h04);
      $display("test reset done");
      host.frame({16'h0, 8'h01, 8'hFC}, 16, rx);
      repeat (40) @(posedge ref_clk);
      check("write without latch", {7'h0, status_protect_bit}, 8'h00);
      host.frame(32'h06, 8, rx);
      repeat (6) @(posedge ref_clk);
      check("latch set", {7'h0, write_enable_latch}, 8'h01);
      rd(8'h95, 8'h06);
      wr({8'h01, 8'hBC, 8'h40, 8'hE3}, 32, 1'b1);
      check("byte after write", config_status_byte_three, 8'hE4);
      check("latch cleared", {7'h0, write_enable_latch}, 8'h00);
      check("dummy long", {dual_dummy_clocks, quad_dummy_clocks}, 8'h8A);
      check("drive 83", {1'b0, drive_percent}, 8'h53);
      check("protect fields", {2'h0, status_protect_bit, boot_sector_lock, protect_from_bottom,
         block_protect_level_2, block_protect_level_1, block_protect_level_0}, 8'h2F);
      check("invert", {7'h0, protect_invert}, 8'h01);
      $display("test generic write done");
      wp_n <= 1'b0;
      repeat (6) @(posedge ref_clk);
      check("locked", {7'h0, hardware_locked_mode}, 8'h01);
      wr({8'h31, 8'h38}, 16, 1'b0);
      check("otp when locked", {5'h0, otp_sector_lock_a, otp_sector_lock_b, otp_sector_lock_c},
         8'h00);
      wp_n <= 1'b1;
      repeat (6) @(posedge ref_clk);
      check("unlocked", {7'h0, hardware_locked_mode}, 8'h00);
      $display("test lock done");
      wr({8'h01, 12'hFFF}, 20, 1'b0);
      check("short frame byte", config_status_byte_three, 8'hE6);
      wr({8'h31, 8'h3A}, 16, 1'b0);
      check("otp and quad", {4'h0, otp_sector_lock_a, otp_sector_lock_b, otp_sector_lock_c,
         quad_pins_enable}, 8'h0F);
      wr({8'h31, 8'h00}, 16, 1'b0);
      check("otp kept", {5'h0, otp_sector_lock_a, otp_sector_lock_b, otp_sector_lock_c},
         8'h07);
      for (int i = 0; i < 2; i++) begin
         wr({ops[i], dat[i]}, 16, 1'b0);
         check("drive pct", {1'b0, drive_percent}, pct[i]);
         check("byte three", config_status_byte_three, dat[i] | 8'h04);
      end
      $display("test dedicated writes done");
      for (int w = 0; w < 4; w++) begin
         @(posedge ref_clk);
         wrap_set <= 1'b1;
         wrap_len <= w[1:0];
         @(posedge ref_clk);
         wrap_set <= 1'b0;
         repeat (3) @(posedge ref_clk);
         check("wrap", {6'h0, config_status_byte_three[4:3]}, {6'h0, w[1:0]});
      end
      first_program <= 1'b1;
      @(posedge ref_clk);
      first_program <= 1'b0;
      repeat (3) @(posedge ref_clk);
      check("blank cleared", {7'h0, config_status_byte_three[2]}, 8'h00);
      array_busy <= 1'b1;
      repeat (3) @(posedge ref_clk);
      check("array busy", {6'h0, busy_flag, config_status_byte_three[0]}, 8'h03);
      array_busy <= 1'b0;
      repeat (4) @(posedge ref_clk);
      check("idle", {7'h0, busy_flag}, 8'h00);
      $display("test indicators done");
      print_verdict();
   end
endmodule // tb_top

//--- hdl/spi_frame_rx.sv
`timescale 1ns/10ps
`include "status_access_consts.svh"
module spi_frame_rx import status_access_pkg::*; (
   input  wire logic       spi_clk,
   input  wire logic       cs_n,
   input  wire logic       serial_data_in,
   input  wire logic [7:0] status_byte,
   output frame_type       frame,
   output logic            miso,
   output logic            miso_oe
);
   logic        fresh_reg;
   logic [5:0]  count_reg;
   logic [2:0]  phase_reg;
   logic [7:0]  opcode_reg;
   logic [23:0] data_reg;
   logic        is_read;
   logic        got_bits_reg;

   // Select high is the frame's own end: it marks the next edge as a first bit
   always_ff @(posedge spi_clk or posedge cs_n) begin
      if (cs_n) begin
         fresh_reg <= 1'b1;
      end else begin
         fresh_reg <= 1'b0;
      end
   end

   // Content is left standing after the frame so the core clock can pick it up
   always_ff @(posedge spi_clk) begin
      if (fresh_reg) begin
         count_reg <= 6'h01;
         phase_reg <= 3'h0;
      end else begin
         if (count_reg != 6'h3F) begin
            count_reg <= count_reg + 6'h01;
         end
         if (count_reg >= `OPCODE_BITS) begin
            phase_reg <= phase_reg + 3'h1;
         end
      end
      if (fresh_reg || count_reg < `OPCODE_BITS) begin
         opcode_reg <= {opcode_reg[6:0], serial_data_in};
      end else begin
         data_reg <= {data_reg[22:0], serial_data_in};
      end
   end

   // Sampled as select rises, before fresh_reg is set again, so a select pulse
   // without clocks is marked empty and never replays the previous command
   always_ff @(posedge cs_n) begin
      got_bits_reg <= !fresh_reg;
   end

   assign is_read = (opcode_reg == `OP_READ_SR3_A) || (opcode_reg == `OP_READ_SR3_B);

   always_ff @(negedge spi_clk or posedge cs_n) begin
      if (cs_n) begin
         miso    <= 1'b0;
         miso_oe <= 1'b0;
      end else if (!fresh_reg && count_reg >= `OPCODE_BITS && is_read) begin
         miso_oe <= 1'b1;
         miso    <= status_byte[3'h7 - phase_reg];
      end
   end

   assign frame = '{empty: !got_bits_reg, opcode: opcode_reg, data: data_reg, bits: count_reg};
endmodule // spi_frame_rx

//--- hdl/status_reg_access.sv
`timescale 1ns/10ps
`include "status_access_consts.svh"
module status_reg_access import status_access_pkg::*; #(
   parameter int WRITE_CYCLES = `STATUS_WRITE_CYCLES
) (
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic       spi_clk,
   input  wire logic       cs_n,
   input  wire logic       serial_data_in,
   input  wire logic       wp_n,
   input  wire logic       array_busy,
   input  wire logic       first_program,
   input  wire logic       wrap_set,
   input  wire logic [1:0] wrap_len,
   output logic            miso,
   output logic            miso_oe,
   output logic [7:0]      config_status_byte_three,
   output logic            busy_flag,
   output logic            write_enable_latch,
   output logic            hardware_locked_mode,
   output logic            extra_latency_select,
   output logic [3:0]      dual_dummy_clocks,
   output logic [3:0]      quad_dummy_clocks,
   output logic [1:0]      drive_strength,
   output logic [6:0]      drive_percent,
   output logic [1:0]      wrap_burst_len,
   output logic            status_protect_bit,
   output logic            protect_invert,
   output logic            boot_sector_lock,
   output logic            protect_from_bottom,
   output logic            block_protect_level_2,
   output logic            block_protect_level_1,
   output logic            block_protect_level_0,
   output logic            otp_sector_lock_a,
   output logic            otp_sector_lock_b,
   output logic            otp_sector_lock_c,
   output logic            quad_pins_enable
);
   frame_type       link_frame;
   frame_type       frame_reg;
   write_state_type state_reg;
   logic       cs_s1_reg;
   logic       cs_s2_reg;
   logic       cs_s3_reg;
   logic       wp_s1_reg;
   logic       wp_s2_reg;
   logic       cmd_valid_reg;
   logic       timer_busy;
   logic       timer_done;
   logic       start_write;
   logic       busy_now;
   logic       locked_now;
   logic [7:0] sr1_reg;
   logic [7:0] sr2_reg;
   logic [2:0] sr3_ctrl_reg;
   logic [1:0] wrap_reg;
   logic       blank_reg;
   logic       wel_reg;
   logic [7:0] pend_sr1_reg;
   logic [7:0] pend_sr2_reg;
   logic [2:0] pend_sr3_reg;
   logic [2:0] pend_mask_reg;
   logic [7:0] sr3_now;
   logic [7:0] status_pub_reg;
   logic       op_generic;
   logic       op_sr2;
   logic       op_sr3;
   logic       op_write_enable_cmd;
   logic       bits_generic_ok;
   logic       bits_single_ok;
   logic [7:0] byte_a;
   logic [7:0] byte_b;
   logic [7:0] byte_c;
   logic [2:0] mask_now;
   logic [7:0] next_sr1;
   logic [7:0] next_sr2;
   logic [2:0] next_sr3;

   spi_frame_rx link_rx (
      .spi_clk        (spi_clk),
      .cs_n           (cs_n),
      .serial_data_in (serial_data_in),
      .status_byte    (status_pub_reg),
      .frame          (link_frame),
      .miso           (miso),
      .miso_oe        (miso_oe)
   );

   status_write_timer #(
      .CYCLES (WRITE_CYCLES)
   ) write_timer (
      .ref_clk (ref_clk),
      .rst     (rst),
      .start   (start_write),
      .busy    (timer_busy),
      .done    (timer_done)
   );

   // Pins from outside the core clock pass two flops first
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cs_s1_reg <= 1'b1;
         cs_s2_reg <= 1'b1;
         cs_s3_reg <= 1'b1;
         wp_s1_reg <= 1'b1;
         wp_s2_reg <= 1'b1;
      end else begin
         cs_s1_reg <= cs_n;
         cs_s2_reg <= cs_s1_reg;
         cs_s3_reg <= cs_s2_reg;
         wp_s1_reg <= wp_n;
         wp_s2_reg <= wp_s1_reg;
      end
   end

   // Frame words stand still once select is high, so the synchronised edge
   // acts as the handshake that makes them safe to take
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         frame_reg     <= '0;
         cmd_valid_reg <= 1'b0;
      end else begin
         cmd_valid_reg <= 1'b0;
         if (cs_s2_reg && !cs_s3_reg) begin
            frame_reg     <= link_frame;
            cmd_valid_reg <= !link_frame.empty;
         end
      end
   end

   // Published copy only moves while no frame runs; the link reads it directly
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         status_pub_reg <= 8'h00;
      end else if (cs_s2_reg) begin
         status_pub_reg <= sr3_now;
      end
   end

   assign busy_now   = timer_busy || array_busy;
   // Quad enable hands the protect pin over to data use, so it no longer locks
   assign locked_now = sr1_reg[`SR1_SRP_POS] && !wp_s2_reg && !sr2_reg[`SR2_QE_POS];

   assign sr3_now = {sr3_ctrl_reg, wrap_reg, blank_reg, wel_reg, busy_now};

   assign op_generic = frame_reg.opcode == `OP_WRITE_STATUS;
   assign op_sr2     = frame_reg.opcode == `OP_WRITE_SR2;
   assign op_sr3     = (frame_reg.opcode == `OP_WRITE_SR3_A) ||
                       (frame_reg.opcode == `OP_WRITE_SR3_B);
   assign op_write_enable_cmd    = frame_reg.opcode == `OP_WRITE_ENABLE;

   // Any other bit count means select rose mid byte or after too few or too many bytes, and the write is dropped
   assign bits_generic_ok = (frame_reg.bits == `FRAME_BITS_ONE) ||
                            (frame_reg.bits == `FRAME_BITS_TWO) ||
                            (frame_reg.bits == `FRAME_BITS_THREE);
   assign bits_single_ok  = frame_reg.bits == `FRAME_BITS_ONE;

   always_comb begin
      byte_a   = 8'h00;
      byte_b   = 8'h00;
      byte_c   = 8'h00;
      mask_now = 3'h0;
      if (op_generic) begin
         case (frame_reg.bits)
            `FRAME_BITS_ONE: begin
               byte_a   = frame_reg.data[7:0];
               mask_now = 3'h1;
            end
            `FRAME_BITS_TWO: begin
               byte_a   = frame_reg.data[15:8];
               byte_b   = frame_reg.data[7:0];
               mask_now = 3'h3;
            end
            `FRAME_BITS_THREE: begin
               byte_a   = frame_reg.data[23:16];
               byte_b   = frame_reg.data[15:8];
               byte_c   = frame_reg.data[7:0];
               mask_now = 3'h7;
            end
            default: begin
               mask_now = 3'h0;
            end
         endcase
      end else if (op_sr2 && bits_single_ok) begin
         byte_b   = frame_reg.data[7:0];
         mask_now = 3'h2;
      end else if (op_sr3 && bits_single_ok) begin
         byte_c   = frame_reg.data[7:0];
         mask_now = 3'h4;
      end
   end

   assign start_write = cmd_valid_reg && (state_reg == ST_IDLE) && wel_reg && !busy_now &&
                        !locked_now && (mask_now != 3'h0) &&
                        (op_generic ? bits_generic_ok : bits_single_ok);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_reg <= ST_IDLE;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (start_write) begin
                  state_reg <= ST_WRITING;
               end
            end
            ST_WRITING: begin
               if (timer_done) begin
                  state_reg <= ST_IDLE;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pend_sr1_reg  <= `SR1_RESET;
         pend_sr2_reg  <= `SR2_RESET;
         pend_sr3_reg  <= `SR3_CTRL_RESET;
         pend_mask_reg <= 3'h0;
      end else if (start_write) begin
         pend_sr1_reg  <= byte_a;
         pend_sr2_reg  <= byte_b;
         pend_sr3_reg  <= byte_c[`SR3_LAT_POS:`SR3_DRV_LSB];
         pend_mask_reg <= mask_now;
      end
   end

   // Data bits 1:0 of the first byte never reach the latch or busy flag
   always_comb begin
      next_sr1 = sr1_reg;
      next_sr2 = sr2_reg;
      next_sr3 = sr3_ctrl_reg;
      if (pend_mask_reg[0]) begin
         next_sr1 = {pend_sr1_reg[7:2], 2'b00};
      end
      if (pend_mask_reg[1]) begin
         next_sr2[`SR2_CMP_POS]   = pend_sr2_reg[`SR2_CMP_POS];
         next_sr2[`SR2_QE_POS]    = pend_sr2_reg[`SR2_QE_POS];
         next_sr2[`SR2_SPL_A_POS] = sr2_reg[`SR2_SPL_A_POS] | pend_sr2_reg[`SR2_SPL_A_POS];
         next_sr2[`SR2_SPL_B_POS] = sr2_reg[`SR2_SPL_B_POS] | pend_sr2_reg[`SR2_SPL_B_POS];
         next_sr2[`SR2_SPL_C_POS] = sr2_reg[`SR2_SPL_C_POS] | pend_sr2_reg[`SR2_SPL_C_POS];
      end
      if (pend_mask_reg[2]) begin
         next_sr3 = pend_sr3_reg;
      end
   end

   // New values land only when the timed cycle ends
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sr1_reg      <= `SR1_RESET;
         sr2_reg      <= `SR2_RESET;
         sr3_ctrl_reg <= `SR3_CTRL_RESET;
      end else if (state_reg == ST_WRITING && timer_done) begin
         sr1_reg      <= next_sr1;
         sr2_reg      <= next_sr2;
         sr3_ctrl_reg <= next_sr3;
      end
   end

   // Write enable while busy is ignored; one landing in the timer_done cycle wins over the clear
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wel_reg <= 1'b0;
      end else if (cmd_valid_reg && op_write_enable_cmd && frame_reg.bits == `OPCODE_BITS && !busy_now) begin
         wel_reg <= 1'b1;
      end else if (state_reg == ST_WRITING && timer_done) begin
         wel_reg <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wrap_reg <= `WRAP_RESET;
      end else if (wrap_set) begin
         wrap_reg <= wrap_len;
      end
   end

   // Only reset sets it again, so erase cannot bring it back
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         blank_reg <= `BLANK_RESET;
      end else if (first_program) begin
         blank_reg <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         config_status_byte_three <= 8'h00;
         busy_flag                <= 1'b0;
         write_enable_latch       <= 1'b0;
         hardware_locked_mode     <= 1'b0;
         wrap_burst_len           <= `WRAP_RESET;
      end else begin
         config_status_byte_three <= sr3_now;
         busy_flag                <= busy_now;
         write_enable_latch       <= wel_reg;
         hardware_locked_mode     <= locked_now;
         wrap_burst_len           <= wrap_reg;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         extra_latency_select <= 1'b0;
         dual_dummy_clocks    <= `DUAL_DUMMY_SHORT;
         quad_dummy_clocks    <= `QUAD_DUMMY_SHORT;
      end else begin
         extra_latency_select <= sr3_ctrl_reg[2];
         dual_dummy_clocks    <= sr3_ctrl_reg[2] ? `DUAL_DUMMY_LONG : `DUAL_DUMMY_SHORT;
         quad_dummy_clocks    <= sr3_ctrl_reg[2] ? `QUAD_DUMMY_LONG : `QUAD_DUMMY_SHORT;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         drive_strength <= 2'b00;
         drive_percent  <= `DRIVE_PCT_00;
      end else begin
         drive_strength <= sr3_ctrl_reg[1:0];
         case (sr3_ctrl_reg[1:0])
            2'b00:   drive_percent <= `DRIVE_PCT_00;
            2'b01:   drive_percent <= `DRIVE_PCT_01;
            2'b10:   drive_percent <= `DRIVE_PCT_10;
            2'b11:   drive_percent <= `DRIVE_PCT_11;
            default: drive_percent <= `DRIVE_PCT_00;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         status_protect_bit    <= 1'b0;
         boot_sector_lock      <= 1'b0;
         protect_from_bottom   <= 1'b0;
         block_protect_level_2 <= 1'b0;
         block_protect_level_1 <= 1'b0;
         block_protect_level_0 <= 1'b0;
         protect_invert        <= 1'b0;
         otp_sector_lock_a     <= 1'b0;
         otp_sector_lock_b     <= 1'b0;
         otp_sector_lock_c     <= 1'b0;
         quad_pins_enable      <= 1'b0;
      end else begin
         status_protect_bit    <= sr1_reg[`SR1_SRP_POS];
         boot_sector_lock      <= sr1_reg[`SR1_BOOT_POS];
         protect_from_bottom   <= sr1_reg[`SR1_TB_POS];
         block_protect_level_2 <= sr1_reg[`SR1_BP_MSB];
         block_protect_level_1 <= sr1_reg[`SR1_BP_MSB-1];
         block_protect_level_0 <= sr1_reg[`SR1_BP_LSB];
         protect_invert        <= sr2_reg[`SR2_CMP_POS];
         otp_sector_lock_a     <= sr2_reg[`SR2_SPL_A_POS];
         otp_sector_lock_b     <= sr2_reg[`SR2_SPL_B_POS];
         otp_sector_lock_c     <= sr2_reg[`SR2_SPL_C_POS];
         quad_pins_enable      <= sr2_reg[`SR2_QE_POS];
      end
   end
endmodule // status_reg_access

//--- hdl/status_write_timer.sv
`timescale 1ns/10ps
module status_write_timer #(
   parameter int CYCLES = 500
) (
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic start,
   output logic      busy,
   output logic      done
);
   localparam int CW = (CYCLES > 1) ? $clog2(CYCLES + 1) : 1;
   logic [CW-1:0] left_reg;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         left_reg <= '0;
         busy     <= 1'b0;
         done     <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start && !busy) begin
            left_reg <= CW'(CYCLES);
            busy     <= 1'b1;
         end else if (busy) begin
            if (left_reg <= CW'(1)) begin
               busy <= 1'b0;
               done <= 1'b1;
            end else begin
               left_reg <= left_reg - CW'(1);
            end
         end
      end
   end
endmodule // status_write_timer

//--- shared/status_access_consts.svh
`ifndef STATUS_ACCESS_CONSTS_SVH
`define STATUS_ACCESS_CONSTS_SVH
`define OP_READ_SR3_A         8'h95
`define OP_READ_SR3_B         8'h15
`define OP_WRITE_STATUS       8'h01
`define OP_WRITE_SR2          8'h31
`define OP_WRITE_SR3_A        8'hC0
`define OP_WRITE_SR3_B        8'h11
`define OP_WRITE_ENABLE       8'h06
`define OPCODE_BITS           6'h08
`define FRAME_BITS_ONE        6'h10
`define FRAME_BITS_TWO        6'h18
`define FRAME_BITS_THREE      6'h20
`define SR1_SRP_POS           7
`define SR1_BOOT_POS          6
`define SR1_TB_POS            5
`define SR1_BP_MSB            4
`define SR1_BP_LSB            2
`define SR2_CMP_POS           6
`define SR2_SPL_A_POS         5
`define SR2_SPL_B_POS         4
`define SR2_SPL_C_POS         3
`define SR2_QE_POS            1
`define SR3_LAT_POS           7
`define SR3_DRV_MSB           6
`define SR3_DRV_LSB           5
`define SR3_WRAP_MSB          4
`define SR3_WRAP_LSB          3
`define SR3_BLANK_POS         2
`define SR3_WEL_POS           1
`define SR3_BUSY_POS          0
`define SR1_RESET             8'h00
`define SR2_RESET             8'h00
`define SR3_CTRL_RESET        3'h0
`define WRAP_RESET            2'h0
`define BLANK_RESET           1'b1
`define DUAL_DUMMY_SHORT      4'h4
`define DUAL_DUMMY_LONG       4'h8
`define QUAD_DUMMY_SHORT      4'h6
`define QUAD_DUMMY_LONG       4'hA
`define DRIVE_PCT_00          7'h43
`define DRIVE_PCT_01          7'h64
`define DRIVE_PCT_10          7'h32
`define DRIVE_PCT_11          7'h53
`define REF_CLK_MHZ           50
`define STATUS_WRITE_CYCLE_TIME_US 10
`define STATUS_WRITE_CYCLES   (`STATUS_WRITE_CYCLE_TIME_US * `REF_CLK_MHZ)
`endif

//--- shared/status_access_pkg.sv
package status_access_pkg;
   typedef struct packed {
      logic        empty;
      logic [7:0]  opcode;
      logic [23:0] data;
      logic [5:0]  bits;
   } frame_type;
   typedef enum logic [1:0] {
      ST_IDLE    = 2'b01,
      ST_WRITING = 2'b10
   } write_state_type;
endpackage
